// ===== hw/bmf_pkg.sv
package bmf_pkg;
  // Data path and memory geometry
  localparam int DATA_W = 36;
  localparam int DEPTH  = 65536;
  localparam int ADDR_W = 16;
  localparam int PTR_W  = 17;
  localparam int OFS_W  = 16;
  localparam int HALF_W = 18;
  localparam int BYTE_W = 9;
  // Number of synchronised pins: 36 data bits plus 20 control pins
  localparam int PIN_W  = 56;
  // Stored word count of a completely full memory
  localparam logic [PTR_W-1:0] DEPTH_CNT = 17'h10000;

  // Bus width configurations, write side first
  typedef enum logic [4:0] {
    BMF_W36_36 = 5'h01,
    BMF_W36_18 = 5'h02,
    BMF_W36_9  = 5'h04,
    BMF_W18_36 = 5'h08,
    BMF_W9_36  = 5'h10
  } bmf_width_e;

  // Values after reset
  localparam logic [DATA_W-1:0] OUT_RST   = 36'h0;
  localparam logic [PTR_W-1:0]  PTR_RST   = 17'h0;
  localparam logic [1:0]        SLICE_RST = 2'h0;
  localparam logic [OFS_W-1:0]  OFS_RST   = 16'h007f;
  localparam bmf_width_e        WIDTH_RST = BMF_W36_36;

  // Read clock edges that hold the empty indication after a rewind
  localparam logic [1:0] RT_HOLD_ZERO = 2'h1;
  localparam logic [1:0] RT_HOLD_NORM = 2'h2;

  // Eight default offsets, indexed by {offset_load, sel_b, sel_a}
  localparam logic [OFS_W-1:0] DEF_OFS [0:7] = '{
    16'h0007, 16'h000f, 16'h001f, 16'h003f,
    16'h007f, 16'h00ff, 16'h01ff, 16'h03ff
  };

  // Index of the last read slice of a stored word
  function automatic logic [1:0] bmf_rd_last(input bmf_width_e w);
    bmf_rd_last = (w == BMF_W36_9) ? 2'h3 : ((w == BMF_W36_18) ? 2'h1 : 2'h0);
  endfunction : bmf_rd_last

  // Index of the last write slice that completes a stored word
  function automatic logic [1:0] bmf_wr_last(input bmf_width_e w);
    bmf_wr_last = (w == BMF_W9_36) ? 2'h3 : ((w == BMF_W18_36) ? 2'h1 : 2'h0);
  endfunction : bmf_wr_last
endpackage : bmf_pkg

// ===== hw/bmf_pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of pins from outside the clock domain
module bmf_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] pins_out
);
  // First stage, read only by the second stage
  logic [W-1:0] meta;

  // Both stages clear to zero under reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta     <= '0;
      pins_out <= '0;
    end else begin
      meta     <= pins_in;
      pins_out <= meta;
    end
  end
endmodule : bmf_pin_sync

// ===== hw/bmf_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// [R1] Full reset picks default offsets and programming method
// [R2] Offset load steers port accesses to offsets
// [R3] Output enable drives or floats read bus
// [R4] Width selects fix read width at reset
// [R5] Full reset zeroes pointers and output register
// [R6] Full reset latches every mode setting
// [R7] Almost-empty low while count below n
// [R8] Almost-full high while free exceeds m
// [R9] Flag timing select picks async/sync flags
// [R10] Partial reset zeroes pointers and output
// [R11] Partial reset keeps modes and offsets
// [R12] Read bus is 36, 18 or 9 bits
// [R13] Synchronous read takes one entry per edge
// [R14] Offset load low reads offsets out
// [R15] Async read takes entry per strobe edge
// [R16] Retransmit latency select picks rewind latency
// [R17] Rewind zeroes read pointer, shows empty
// [R18] Latched inputs stay steady after reset
// [R19] Valid flag in lookahead, empty otherwise
// [R20] Lookahead select picks timing at reset
// [R21] Async read requires standard mode
// [R22] Sync flags update on own port clocks
module bmf_ctrl
  import bmf_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire logic [bmf_pkg::DATA_W-1:0] write_data_in,
  input  wire logic                      write_clock_in,
  input  wire logic                      write_enable_n_in,
  input  wire logic                      read_clock_in,
  input  wire logic                      read_enable_n_in,
  input  wire logic                      offset_load_n_in,
  input  wire logic                      output_enable_n_in,
  input  wire logic                      full_reset_n_in,
  input  wire logic                      partial_reset_n_in,
  input  wire logic                      rewind_request_in,
  input  wire logic                      default_offset_sel_a_in,
  input  wire logic                      default_offset_sel_b_in,
  input  wire logic                      lookahead_mode_in,
  input  wire logic                      async_read_select_n_in,
  input  wire logic                      flag_timing_select_in,
  input  wire logic                      retransmit_latency_select_in,
  input  wire logic                      byte_order_select_in,
  input  wire logic                      parity_select_in,
  input  wire logic                      write_width_select_in,
  input  wire logic                      read_width_select_in,
  input  wire logic                      width_matching_select_in,
  output logic [bmf_pkg::DATA_W-1:0]     read_data_bus_out,
  output logic                           read_data_oe_out,
  output logic                           empty_indicator_n_out,
  output logic                           almost_empty_flag_n_out,
  output logic                           almost_full_flag_n_out
);
  import bmf_pkg::*;

  // Synchronised pins
  logic [PIN_W-1:0]  pins;      // Bundle after two flops
  logic [DATA_W-1:0] s_wdata;   // Write data
  logic              s_wclk;    // Write clock level
  logic              s_wen_n;   // Write enable
  logic              s_rclk;    // Read clock or strobe level
  logic              s_ren_n;   // Read enable
  logic              s_ld_n;    // Offset load
  logic              s_oe_n;    // Output enable
  logic              s_frst_n;  // Full reset
  logic              s_prst_n;  // Partial reset
  logic              s_rt;      // Rewind request
  logic              s_sel_a;   // Default offset select a
  logic              s_sel_b;   // Default offset select b
  logic              s_look;    // Lookahead select
  logic              s_async_read_select_n;  // Async read select
  logic              s_pfm;     // Flag timing select
  logic              s_rm;      // Retransmit latency select
  logic              s_be;      // Byte order select
  logic              s_ip;      // Parity select
  logic              s_iw;      // Write width select
  logic              s_ow;      // Read width select
  logic              s_bm;      // Width matching select

  // All pins share one synchroniser so data and strobes stay aligned
  bmf_pin_sync #(.W(PIN_W)) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pins_in  ({width_matching_select_in, read_width_select_in, write_width_select_in,
                parity_select_in, byte_order_select_in, retransmit_latency_select_in,
                flag_timing_select_in, async_read_select_n_in, lookahead_mode_in,
                default_offset_sel_b_in, default_offset_sel_a_in, rewind_request_in,
                partial_reset_n_in, full_reset_n_in, output_enable_n_in,
                offset_load_n_in, read_enable_n_in, read_clock_in,
                write_enable_n_in, write_clock_in, write_data_in}),
    .pins_out (pins)
  );
  assign {s_bm, s_ow, s_iw, s_ip, s_be, s_rm, s_pfm, s_async_read_select_n, s_look, s_sel_b, s_sel_a,
          s_rt, s_prst_n, s_frst_n, s_oe_n, s_ld_n, s_ren_n, s_rclk, s_wen_n, s_wclk,
          s_wdata} = pins;

  // Latched configuration
  bmf_width_e cfg_width;       // Port width pairing
  logic       cfg_lookahead;   // Lookahead timing
  logic       cfg_parallel;    // Parallel offset programming
  logic       cfg_little;      // Little-endian slice order
  logic       cfg_rt_normal;   // Normal-latency rewind
  logic       cfg_parity;      // Interspersed parity on offset writes
  logic       cfg_sync_flags;  // Synchronous almost-flag timing
  logic       cfg_async_read;  // Read strobe instead of read clock

  // Port and memory state
  logic [DATA_W-1:0] mem [0:DEPTH-1];  // Word storage
  logic [PTR_W-1:0]  wr_ptr;           // Write pointer with wrap bit
  logic [PTR_W-1:0]  rd_ptr;           // Read pointer with wrap bit
  logic [1:0]        wr_slice;         // Narrow write slice index
  logic [1:0]        rd_slice;         // Narrow read slice index
  logic [DATA_W-1:0] wr_acc;           // Word being packed
  logic [DATA_W-1:0] out_q;            // Output register
  logic              out_valid;        // Word present on outputs
  logic [1:0]        rt_hold;          // Read edges left after a rewind
  logic [OFS_W-1:0]  empty_ofs;        // Offset n
  logic [OFS_W-1:0]  full_ofs;         // Offset m
  logic              ofs_wsel;         // Next offset to write
  logic              ofs_rsel;         // Next offset to read
  logic              wclk_q;           // Previous write clock level
  logic              rclk_q;           // Previous read clock level

  // Reset and edge decode
  wire full_rst = ~s_frst_n;
  wire part_rst = ~s_prst_n;
  wire any_rst  = full_rst | part_rst;
  wire wr_rise  = s_wclk & ~wclk_q;
  wire rd_rise  = s_rclk & ~rclk_q;

  // Configuration decoded from the live pins while full reset is held
  bmf_width_e next_width;
  assign next_width = !s_bm ? BMF_W36_36 :  // R4
                      (s_iw ? (s_ow ? BMF_W9_36 : BMF_W18_36)
                            : (s_ow ? BMF_W36_9 : BMF_W36_18));
  wire [2:0] next_ofs_idx = {s_ld_n, s_sel_b, s_sel_a};  // R1

  // Word count and threshold compares
  wire [PTR_W-1:0] count    = wr_ptr - rd_ptr;
  wire [PTR_W-1:0] free_cnt = DEPTH_CNT - count;
  wire             mem_has  = (count != PTR_RST);
  wire             mem_full = (count == DEPTH_CNT);
  wire             ae_cond  = (count >= {1'b0, empty_ofs});  // R7
  wire             af_cond  = (free_cnt > {1'b0, full_ofs});  // R8

  // Write side decode
  wire       wr_go    = wr_rise & ~s_wen_n & ~any_rst;
  wire       ofs_wr   = wr_go & ~s_ld_n & cfg_parallel;  // R2
  wire       data_wr  = wr_go & s_ld_n & ~mem_full;
  wire [1:0] wr_last  = bmf_wr_last(cfg_width);
  wire       wr_done  = data_wr & (wr_slice == wr_last);
  wire [1:0] wr_pos   = cfg_little ? wr_slice : wr_last - wr_slice;
  wire [OFS_W-1:0] ofs_value = cfg_parity ? {s_wdata[16:9], s_wdata[7:0]} : s_wdata[15:0];

  // Read side decode
  wire       rd_edge  = rd_rise & ~any_rst;
  wire       rd_go    = rd_edge & (cfg_async_read | ~s_ren_n);  // R13 R15
  wire       rewind   = rd_edge & s_rt & ~cfg_async_read;  // R17
  wire       ofs_rd   = rd_go & ~s_ld_n & ~cfg_async_read & ~rewind;  // R14
  wire       data_rd  = rd_go & (s_ld_n | cfg_async_read) & ~rewind;
  wire       look_pull = rd_edge & ~rewind & s_ld_n & (~out_valid | ~s_ren_n);
  wire       take     = (rt_hold == SLICE_RST) & mem_has &
                        (cfg_lookahead ? look_pull : data_rd);  // R19
  wire       drop     = cfg_lookahead & look_pull & ~take;
  wire [1:0] rd_last  = bmf_rd_last(cfg_width);
  wire [1:0] rd_pos   = cfg_little ? rd_slice : rd_last - rd_slice;
  wire [DATA_W-1:0] rd_word = mem[rd_ptr[ADDR_W-1:0]];

  // Merge a narrow write slice into the packing word
  logic [DATA_W-1:0] wr_merge;
  always_comb begin
    wr_merge = wr_acc;
    unique case (cfg_width)
      BMF_W18_36: wr_merge[rd_sel18(wr_pos) +: HALF_W] = s_wdata[HALF_W-1:0];
      BMF_W9_36:  wr_merge[32'(wr_pos) * BYTE_W +: BYTE_W] = s_wdata[BYTE_W-1:0];
      BMF_W36_36, BMF_W36_18, BMF_W36_9: wr_merge = s_wdata;
    endcase
  end

  // Select the read slice; bits above the port width read as zero
  logic [DATA_W-1:0] rd_slice_data;
  always_comb begin
    rd_slice_data = OUT_RST;
    unique case (cfg_width)  // R12
      BMF_W36_18: rd_slice_data[HALF_W-1:0] = rd_word[rd_sel18(rd_pos) +: HALF_W];
      BMF_W36_9:  rd_slice_data[BYTE_W-1:0] = rd_word[32'(rd_pos) * BYTE_W +: BYTE_W];
      BMF_W36_36, BMF_W18_36, BMF_W9_36: rd_slice_data = rd_word;
    endcase
  end

  // Bit offset of a half-word slice
  function automatic int rd_sel18(input logic [1:0] pos);
    rd_sel18 = pos[0] ? HALF_W : 0;
  endfunction : rd_sel18

  // Edge detect history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      wclk_q <= s_wclk;
      rclk_q <= s_rclk;
    end
  end

  // Mode settings follow the pins only while full reset is held
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_width      <= WIDTH_RST;
      cfg_lookahead  <= 1'b0;
      cfg_parallel   <= 1'b0;
      cfg_little     <= 1'b0;
      cfg_rt_normal  <= 1'b0;
      cfg_parity     <= 1'b0;
      cfg_sync_flags <= 1'b0;
      cfg_async_read <= 1'b0;
    end else if (full_rst) begin  // R6
      cfg_width      <= next_width;  // R4
      cfg_lookahead  <= s_look;  // R20
      cfg_parallel   <= s_ld_n;  // R1
      cfg_little     <= s_be;
      cfg_rt_normal  <= s_rm;  // R16
      cfg_parity     <= s_ip;
      cfg_sync_flags <= s_pfm;  // R9
      cfg_async_read <= ~s_async_read_select_n;
    end
  end

  // Offset registers: defaults at full reset, kept by partial reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      empty_ofs <= OFS_RST;
      full_ofs  <= OFS_RST;
      ofs_wsel  <= 1'b0;
      ofs_rsel  <= 1'b0;
    end else if (full_rst) begin
      empty_ofs <= DEF_OFS[next_ofs_idx];  // R1
      full_ofs  <= DEF_OFS[next_ofs_idx];
      ofs_wsel  <= 1'b0;
      ofs_rsel  <= 1'b0;
    end else begin  // R11
      if (ofs_wr) begin  // R2
        ofs_wsel <= ~ofs_wsel;
        if (ofs_wsel) full_ofs <= ofs_value;
        else empty_ofs <= ofs_value;
      end
      if (ofs_rd) ofs_rsel <= ~ofs_rsel;
    end
  end

  // Write pointer and packing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr   <= PTR_RST;
      wr_slice <= SLICE_RST;
      wr_acc   <= OUT_RST;
    end else if (any_rst) begin  // R5 R10
      wr_ptr   <= PTR_RST;
      wr_slice <= SLICE_RST;
      wr_acc   <= OUT_RST;
    end else if (data_wr) begin
      wr_acc   <= wr_merge;
      wr_slice <= wr_done ? SLICE_RST : wr_slice + 2'h1;
      if (wr_done) wr_ptr <= wr_ptr + 17'h1;
    end
  end

  // Storage is written only when a whole word is packed
  always_ff @(posedge clk_in) begin
    if (wr_done) mem[wr_ptr[ADDR_W-1:0]] <= wr_merge;
  end

  // Read pointer, output register and rewind
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_ptr    <= PTR_RST;
      rd_slice  <= SLICE_RST;
      out_q     <= OUT_RST;
      out_valid <= 1'b0;
      rt_hold   <= SLICE_RST;
    end else if (any_rst) begin  // R5 R10
      rd_ptr    <= PTR_RST;
      rd_slice  <= SLICE_RST;
      out_q     <= OUT_RST;
      out_valid <= 1'b0;
      rt_hold   <= SLICE_RST;
    end else if (rewind) begin  // R17
      rd_ptr    <= PTR_RST;
      rd_slice  <= SLICE_RST;
      out_valid <= 1'b0;
      rt_hold   <= cfg_rt_normal ? RT_HOLD_NORM : RT_HOLD_ZERO;  // R16
    end else begin
      if (rd_edge && rt_hold != SLICE_RST) rt_hold <= rt_hold - 2'h1;
      if (ofs_rd) begin  // R14
        out_q <= {20'h0, ofs_rsel ? full_ofs : empty_ofs};
      end else if (take) begin  // R13 R15
        out_q     <= rd_slice_data;
        out_valid <= 1'b1;
        rd_slice  <= (rd_slice == rd_last) ? SLICE_RST : rd_slice + 2'h1;
        if (rd_slice == rd_last) rd_ptr <= rd_ptr + 17'h1;
      end else if (drop) begin
        out_valid <= 1'b0;
      end
    end
  end

  // Status flags; sync timing moves each almost flag only on its own port edge
  wire ae_tick = ~cfg_sync_flags | rd_rise;  // R22
  wire af_tick = ~cfg_sync_flags | wr_rise;  // R22
  wire next_ef_n = cfg_lookahead ? ~out_valid : (mem_has & (rt_hold == SLICE_RST));  // R19
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      empty_indicator_n_out   <= 1'b0;
      almost_empty_flag_n_out <= 1'b0;
      almost_full_flag_n_out  <= 1'b1;
    end else if (any_rst) begin
      empty_indicator_n_out   <= cfg_lookahead;
      almost_empty_flag_n_out <= 1'b0;
      almost_full_flag_n_out  <= 1'b1;
    end else begin
      empty_indicator_n_out <= next_ef_n;
      if (ae_tick) almost_empty_flag_n_out <= ae_cond;  // R7 R9
      if (af_tick) almost_full_flag_n_out <= af_cond;  // R8 R9
    end
  end

  // Read bus comes from the output register; enable follows the pin
  assign read_data_bus_out = out_q;
  assign read_data_oe_out  = ~s_oe_n;  // R3

  // Checks
  a_full_reset_clear: assert property (@(posedge clk_in) disable iff (rst_in)  // R5
    full_rst |=> (out_q == OUT_RST) && (rd_ptr == PTR_RST) && (wr_ptr == PTR_RST))
    else $error("full reset left pointers or output set");
  a_part_reset_keep: assert property (@(posedge clk_in) disable iff (rst_in)  // R11
    (part_rst && !full_rst) |=> $stable(empty_ofs) && $stable(full_ofs) && $stable(cfg_width)
      && (rd_ptr == PTR_RST) && (out_q == OUT_RST))
    else $error("partial reset disturbed settings or kept data");
  a_cfg_frozen: assert property (@(posedge clk_in) disable iff (rst_in)  // R6
    !full_rst |=> $stable(cfg_lookahead) && $stable(cfg_sync_flags) && $stable(cfg_rt_normal))
    else $error("configuration changed outside full reset");
  a_oe_follows: assert property (@(posedge clk_in) disable iff (rst_in)  // R3
    $fell(s_oe_n) |-> read_data_oe_out)
    else $error("read bus not driven while enabled");
  a_ae_async: assert property (@(posedge clk_in) disable iff (rst_in)  // R7
    (!cfg_sync_flags && !any_rst && !full_rst) |=> almost_empty_flag_n_out == $past(ae_cond))
    else $error("almost-empty flag wrong against offset n");
  a_af_async: assert property (@(posedge clk_in) disable iff (rst_in)  // R8
    (!cfg_sync_flags && !any_rst) |=> almost_full_flag_n_out == $past(af_cond))
    else $error("almost-full flag wrong against offset m");
  a_ae_sync_hold: assert property (@(posedge clk_in) disable iff (rst_in)  // R22
    (cfg_sync_flags && !rd_rise && !any_rst) |=> $stable(almost_empty_flag_n_out))
    else $error("sync almost-empty moved without read edge");
  a_rewind_zero: assert property (@(posedge clk_in) disable iff (rst_in)  // R17
    rewind |=> (rd_ptr == PTR_RST) && $stable(wr_ptr) && !out_valid ##1
      (cfg_lookahead || !empty_indicator_n_out))
    else $error("rewind did not restart read side");
  a_read_step: assert property (@(posedge clk_in) disable iff (rst_in)  // R13
    (take && rd_slice == rd_last) |=> rd_ptr == $past(rd_ptr) + 17'h1)
    else $error("read did not advance one entry");
  a_async_read: assert property (@(posedge clk_in) disable iff (rst_in)  // R15
    (cfg_async_read && !cfg_lookahead && rd_edge && !s_rt && mem_has && rt_hold == SLICE_RST)
      |=> $changed(rd_ptr) || $changed(rd_slice))
    else $error("strobe edge did not read");
endmodule : bmf_ctrl

// ===== verification/bmf_port_model.sv
`timescale 1ns/1ps
// Writer and reader logic on the far side of both ports
module bmf_port_model (
  input  wire logic        clk_in,
  output logic      [35:0] wdata_out,
  output logic             wclk_out,
  output logic             wen_n_out,
  output logic             rclk_out,
  output logic             ren_n_out,
  output logic             rewind_out
);
  // Idle state: both clocks still, enables off
  initial begin
    wdata_out  = 36'h0;
    wclk_out   = 1'b0;
    wen_n_out  = 1'b1;
    rclk_out   = 1'b0;
    ren_n_out  = 1'b1;
    rewind_out = 1'b0;
  end

  // One write clock frame of 400 ns; enable settles one cycle before the edge
  task automatic wr(input logic [35:0] d);
    @(posedge clk_in);
    wdata_out <= d;
    wen_n_out <= 1'b0;
    @(posedge clk_in);
    wclk_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    wclk_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    wen_n_out <= 1'b1;
    // Released bus shows the inverse so stale data never looks valid
    wdata_out <= ~d;
  endtask : wr

  // One read clock frame of 400 ns, with or without a rewind request
  task automatic rd(input logic rt);
    @(posedge clk_in);
    ren_n_out  <= 1'b0;
    rewind_out <= rt;
    @(posedge clk_in);
    rclk_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    rclk_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    ren_n_out  <= 1'b1;
    rewind_out <= 1'b0;
  endtask : rd
endmodule : bmf_port_model

// ===== verification/tb_bus_matching_fifo_control.sv
`timescale 1ns/1ps
// Self-checking bench for the FIFO control block
module tb_bus_matching_fifo_control;
  import bmf_pkg::*;
  logic        clk_in, rst_in;
  logic [35:0] wd, rq;
  logic        wclk, wen_n, rclk, ren_n, rt;
  logic        ld_n, oe_n, mrs_n, prs_n, oe, ef_n, ae_n, af_n;
  logic        sel_a, sel_b, look, async_read_select_n, flag_timing_select, rm, be, ip, iw, ow, bm;
  int          n_errors, tests_run;

  // System clock, 40 ns
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  bmf_port_model peer (.clk_in(clk_in), .wdata_out(wd), .wclk_out(wclk), .wen_n_out(wen_n),
    .rclk_out(rclk), .ren_n_out(ren_n), .rewind_out(rt));

  // Mode pins change only while full reset is held
  bmf_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .write_data_in(wd), .write_clock_in(wclk),
    .write_enable_n_in(wen_n), .read_clock_in(rclk), .read_enable_n_in(ren_n),
    .offset_load_n_in(ld_n), .output_enable_n_in(oe_n), .full_reset_n_in(mrs_n),
    .partial_reset_n_in(prs_n), .rewind_request_in(rt), .default_offset_sel_a_in(sel_a),
    .default_offset_sel_b_in(sel_b), .lookahead_mode_in(look), .async_read_select_n_in(async_read_select_n),
    .flag_timing_select_in(flag_timing_select), .retransmit_latency_select_in(rm),
    .byte_order_select_in(be), .parity_select_in(ip), .write_width_select_in(iw),
    .read_width_select_in(ow), .width_matching_select_in(bm), .read_data_bus_out(rq),
    .read_data_oe_out(oe), .empty_indicator_n_out(ef_n), .almost_empty_flag_n_out(ae_n),
    .almost_full_flag_n_out(af_n));

  // Compare one value and count it
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard, far beyond the about 220 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    n_errors  = 0;
    tests_run = 0;
    rst_in    = 1'b1;
    ld_n      = 1'b1;
    oe_n      = 1'b0;
    mrs_n     = 1'b0;
    prs_n     = 1'b1;
    // First setup: 36/36, standard, sync read, async flags, zero latency
    {sel_a, sel_b, look, flag_timing_select, rm, be, ip, iw, ow, bm} = 10'h0;
    async_read_select_n    = 1'b1;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    mrs_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("rq_reset", rq, 36'h0);
    check("ef_reset", {35'h0, ef_n}, 36'h0);
    check("ae_reset", {35'h0, ae_n}, 36'h0);
    check("af_reset", {35'h0, af_n}, 36'h1);
    // Default offsets read back, then new ones written and read back
    ld_n <= 1'b0;
    peer.rd(1'b0);
    check("def_n", rq, 36'h7f);
    peer.rd(1'b0);
    check("def_m", rq, 36'h7f);
    peer.wr(36'h3);
    peer.wr(36'h5);
    peer.rd(1'b0);
    check("ofs_n", rq, 36'h3);
    peer.rd(1'b0);
    check("ofs_m", rq, 36'h5);
    ld_n <= 1'b1;
    // Three words: almost-empty rises exactly when count reaches n
    for (int i = 0; i < 3; i++) begin
      peer.wr(36'ha5a50000 + 36'(i));
      repeat (2) @(posedge clk_in);
      check("ae_fill", {35'h0, ae_n}, (i == 2) ? 36'h1 : 36'h0);
      check("ef_fill", {35'h0, ef_n}, 36'h1);
    end
    peer.rd(1'b0);
    check("rd_w0", rq, 36'ha5a50000);
    check("ae_drop", {35'h0, ae_n}, 36'h0);
    // Rewind: empty shown, one read refused, then data from the start
    peer.rd(1'b1);
    check("ef_rewind", {35'h0, ef_n}, 36'h0);
    peer.rd(1'b0);
    peer.rd(1'b0);
    check("rd_again0", rq, 36'ha5a50000);
    peer.rd(1'b0);
    check("rd_again1", rq, 36'ha5a50001);
    // Output drive enable
    oe_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("oe_off", {35'h0, oe}, 36'h0);
    oe_n <= 1'b0;
    repeat (3) @(posedge clk_in);
    check("oe_on", {35'h0, oe}, 36'h1);
    // Partial reset clears data path, keeps programmed offsets
    prs_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    check("rq_prs", rq, 36'h0);
    check("ef_prs", {35'h0, ef_n}, 36'h0);
    prs_n <= 1'b1;
    ld_n  <= 1'b0;
    peer.rd(1'b0);
    check("ofs_keep", rq, 36'h3);
    ld_n <= 1'b1;
    check("af_free", {35'h0, af_n}, 36'h1);
    // Second full reset: async read strobe, sync flags, normal latency
    mrs_n  <= 1'b0;
    async_read_select_n <= 1'b0;
    look   <= 1'b0;
    flag_timing_select    <= 1'b1;
    rm     <= 1'b1;
    repeat (6) @(posedge clk_in);
    mrs_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("ef_mrs2", {35'h0, ef_n}, 36'h0);
    peer.wr(36'h5a5a5a5a5);
    repeat (2) @(posedge clk_in);
    check("ef_async", {35'h0, ef_n}, 36'h1);
    peer.rd(1'b0);
    check("rd_async", rq, 36'h5a5a5a5a5);
    report_and_stop();
  end
endmodule : tb_bus_matching_fifo_control
